/* cifam_regs.sv */
// Summary of operation
// - command bit 7 at 0 copies the requested object into the buffer
// - buffer mask fields share the stored message object layout bit for bit
// - identifier mask bit 0 lets that received bit never block a match
// - identifier mask bit 1 compares received against stored bit, except bits 17:0 when the object has extended flag 0
// - bit 14 includes direction in filtering when 1, resets to 1
// - bit 15 includes extended flag in filtering when 1, resets to 1
// - low mask holds id mask 15:0, resets 0xFFFF, upper half reads 0
// - high mask holds id mask 28:16 in 12:0 reset 0xFFF, bit 13 is 1
// - two independent interfaces each own a mask set at separate addresses
// - extended flag 1 uses 29-bit id, 0 uses 11-bit standard id
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cifam_regs #(
  parameter int OBJ_NUM = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic [31:0]              reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [31:0]              reg_rdata,
  input  wire cifam_pkg::cifam_cmd_type cmd_req,
  output var  logic                     busy,
  output var  logic                     ram_rd,
  output var  logic                     ram_wr,
  output var  logic [5:0]               ram_addr,
  output var  cifam_pkg::cifam_mask_type ram_wdata,
  input  wire cifam_pkg::cifam_mask_type ram_rdata,
  input  wire cifam_pkg::cifam_filt_type filt_req,
  output var  logic                     filt_valid,
  output var  logic                     filt_match
);

  // ==========================================================
  // elaboration check
  // ==========================================================
  if (OBJ_NUM < 1 || OBJ_NUM > 64)
  begin : g_bad_obj_num
    $error("OBJ_NUM must lie between 1 and 64");
  end

  // ==========================================================
  // functions
  // ==========================================================
  // decode: {hit, interface two, high word}
  function automatic logic [2:0] reg_decode(input logic [31:0] a);
    logic [2:0] r;
    r = 3'b000;
    case (a)
      cifam_pkg::IF1_ID_MASK_LOW_ADDR:  r = 3'b100;
      cifam_pkg::IF1_ID_MASK_HIGH_ADDR: r = 3'b101;
      cifam_pkg::IF2_ID_MASK_LOW_ADDR:  r = 3'b110;
      cifam_pkg::IF2_ID_MASK_HIGH_ADDR: r = 3'b111;
      default:                          r = 3'b000;
    endcase
    return r;
  endfunction : reg_decode

  // acceptance test of one received frame against one object
  function automatic logic accept(input cifam_pkg::cifam_filt_type f);
    logic [28:0] care;
    logic        id_ok;
    logic        dir_ok;
    logic        ext_ok;
    care = f.obj_mask.id_mask;
    if (f.extended_id_flag == 1'b0)
    begin
      care[cifam_pkg::STD_ID_LSB-1:0] = '0;
    end
    id_ok  = ((f.rx_id ^ f.obj_id) & care) == 29'h0;
    dir_ok = !f.obj_mask.direction_mask_enable
             || (f.rx_dir == f.obj_dir);
    ext_ok = !f.obj_mask.extended_flag_mask_enable
             || (f.rx_ext == f.extended_id_flag);
    return id_ok && dir_ok && ext_ok;
  endfunction : accept

  // ==========================================================
  // mask buffer registers, one set per interface
  // ==========================================================
  cifam_pkg::cifam_mask_type mask_q [2];
  cifam_pkg::cifam_mask_type mask_d [2];
  cifam_pkg::cifam_state_type state_q;
  cifam_pkg::cifam_state_type state_d;
  logic                       load_if_q;
  logic                       load_if_d;
  logic [2:0]                 wr_dec;

  assign wr_dec = reg_decode(reg_addr);

  // a transfer load beats a same-cycle software write to that set
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      mask_d[i] = mask_q[i];
      if (reg_wr && wr_dec[2] && (wr_dec[1] == i[0]))
      begin
        if (!wr_dec[0])
        begin
          mask_d[i].id_mask[15:0] =
            reg_wdata[cifam_pkg::LOW_FIELD_LSB +: cifam_pkg::LOW_FIELD_W];
        end
        else
        begin
          mask_d[i].id_mask[28:16] =
            reg_wdata[cifam_pkg::HIGH_FIELD_LSB +: cifam_pkg::HIGH_FIELD_W];
          mask_d[i].direction_mask_enable =
            reg_wdata[cifam_pkg::DIR_EN_POS];
          mask_d[i].extended_flag_mask_enable =
            reg_wdata[cifam_pkg::EXT_EN_POS];
        end
      end
      if ((state_q == cifam_pkg::ST_LOAD) && (load_if_q == i[0]))
      begin
        mask_d[i] = ram_rdata;
      end
    end
  end

  // reset values match the printed field resets
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q[0] <= cifam_pkg::MASK_RST;
      mask_q[1] <= cifam_pkg::MASK_RST;
    end
    else
    begin
      mask_q[0] <= mask_d[0];
      mask_q[1] <= mask_d[1];
    end
  end

  // ==========================================================
  // transfer control towards message RAM
  // ==========================================================
  logic                      ram_rd_q;
  logic                      ram_rd_d;
  logic                      ram_wr_q;
  logic                      ram_wr_d;
  logic [5:0]                ram_addr_q;
  logic [5:0]                ram_addr_d;
  cifam_pkg::cifam_mask_type ram_wdata_q;
  cifam_pkg::cifam_mask_type ram_wdata_d;
  logic                      busy_q;
  logic                      busy_d;

  // requests arriving while a read is in flight are dropped
  always_comb
  begin
    state_d     = state_q;
    load_if_d   = load_if_q;
    ram_rd_d    = 1'b0;
    ram_wr_d    = 1'b0;
    ram_addr_d  = ram_addr_q;
    ram_wdata_d = ram_wdata_q;
    case (state_q)
      cifam_pkg::ST_IDLE:
      begin
        if (cmd_req.valid && cmd_req.mask_access)
        begin
          ram_addr_d = cmd_req.obj_num;
          load_if_d  = cmd_req.if_sel;
          if (cmd_req.cmd_mask[cifam_pkg::CMD_WR_RD_POS] ==
              cifam_pkg::CMD_READ_XFER)
          begin
            ram_rd_d = 1'b1;
            state_d  = cifam_pkg::ST_READ;
          end
          else
          begin
            // software has loaded the buffer beforehand
            ram_wr_d    = 1'b1;
            ram_wdata_d = mask_q[cmd_req.if_sel];
          end
        end
      end
      cifam_pkg::ST_READ:
      begin
        state_d = cifam_pkg::ST_LOAD;
      end
      cifam_pkg::ST_LOAD:
      begin
        state_d = cifam_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = cifam_pkg::ST_IDLE;
      end
    endcase
    busy_d = (state_d != cifam_pkg::ST_IDLE);
  end

  // registers of the transfer path
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q     <= cifam_pkg::ST_IDLE;
      load_if_q   <= 1'b0;
      ram_rd_q    <= 1'b0;
      ram_wr_q    <= 1'b0;
      ram_addr_q  <= 6'h00;
      ram_wdata_q <= cifam_pkg::MASK_RST;
      busy_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      load_if_q   <= load_if_d;
      ram_rd_q    <= ram_rd_d;
      ram_wr_q    <= ram_wr_d;
      ram_addr_q  <= ram_addr_d;
      ram_wdata_q <= ram_wdata_d;
      busy_q      <= busy_d;
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0]  rd_dec;

  assign rd_dec = reg_decode(reg_addr);

  // unmapped addresses read zero; reserved bits read their reset
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_rd && rd_dec[2])
    begin
      if (!rd_dec[0])
      begin
        rdata_d[15:0] = mask_q[rd_dec[1]].id_mask[15:0];
      end
      else
      begin
        rdata_d[12:0] = mask_q[rd_dec[1]].id_mask[28:16];
        rdata_d[cifam_pkg::HIGH_RSVD_POS] =
          cifam_pkg::HIGH_RSVD_VAL;
        rdata_d[cifam_pkg::DIR_EN_POS] =
          mask_q[rd_dec[1]].direction_mask_enable;
        rdata_d[cifam_pkg::EXT_EN_POS] =
          mask_q[rd_dec[1]].extended_flag_mask_enable;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // acceptance filter
  // ==========================================================
  logic filt_valid_q;
  logic filt_valid_d;
  logic filt_match_q;
  logic filt_match_d;

  // registered so the compare tree does not reach the outputs
  always_comb
  begin
    filt_valid_d = filt_req.valid;
    filt_match_d = filt_req.valid && accept(filt_req);
  end

  // filter result register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      filt_valid_q <= 1'b0;
      filt_match_q <= 1'b0;
    end
    else
    begin
      filt_valid_q <= filt_valid_d;
      filt_match_q <= filt_match_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign reg_rdata  = rdata_q;
  assign busy       = busy_q;
  assign ram_rd     = ram_rd_q;
  assign ram_wr     = ram_wr_q;
  assign ram_addr   = ram_addr_q;
  assign ram_wdata  = ram_wdata_q;
  assign filt_valid = filt_valid_q;
  assign filt_match = filt_match_q;

endmodule : cifam_regs
`default_nettype wire

/* cifam_pkg.sv */
`default_nettype none
package cifam_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [31:0] IF1_ID_MASK_LOW_ADDR  = 32'h4005_0028;
  localparam logic [31:0] IF1_ID_MASK_HIGH_ADDR = 32'h4005_002c;
  localparam logic [31:0] IF2_ID_MASK_LOW_ADDR  = 32'h4005_0088;
  localparam logic [31:0] IF2_ID_MASK_HIGH_ADDR = 32'h4005_008c;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int LOW_FIELD_LSB    = 0;
  localparam int LOW_FIELD_W      = 16;
  localparam int HIGH_FIELD_LSB   = 0;
  localparam int HIGH_FIELD_W     = 13;
  localparam int HIGH_RSVD_POS    = 13;
  localparam int DIR_EN_POS       = 14;
  localparam int EXT_EN_POS       = 15;
  localparam int STD_ID_LSB       = 18;
  localparam int CMD_WR_RD_POS    = 7;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [15:0] LOW_FIELD_RST  = 16'hffff;
  localparam logic [12:0] HIGH_FIELD_RST = 13'h0fff;
  localparam logic        HIGH_RSVD_VAL  = 1'b1;
  localparam logic        DIR_EN_RST     = 1'b1;
  localparam logic        EXT_EN_RST     = 1'b1;
  localparam logic        CMD_READ_XFER  = 1'b0;

  // ==========================================================
  // types
  // ==========================================================
  // same layout as the mask word of a stored message object
  typedef struct packed {
    logic        extended_flag_mask_enable;
    logic        direction_mask_enable;
    logic [28:0] id_mask;
  } cifam_mask_type;

  localparam cifam_mask_type MASK_RST = '{
    extended_flag_mask_enable: EXT_EN_RST,
    direction_mask_enable:     DIR_EN_RST,
    id_mask:                   {HIGH_FIELD_RST, LOW_FIELD_RST}
  };

  typedef struct packed {
    logic       valid;
    logic       if_sel;       // 0: interface one, 1: interface two
    logic [7:0] cmd_mask;     // command mask byte, bit 7 direction
    logic       mask_access;  // move the mask word at all
    logic [5:0] obj_num;
  } cifam_cmd_type;

  typedef struct packed {
    logic           valid;
    logic [28:0]    rx_id;
    logic           rx_dir;
    logic           rx_ext;
    logic [28:0]    obj_id;
    logic           obj_dir;
    logic           extended_id_flag;
    cifam_mask_type obj_mask;
  } cifam_filt_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_LOAD = 3'b100
  } cifam_state_type;
endpackage : cifam_pkg
`default_nettype wire

/* cifam_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cifam_regs_monitor (
  input wire logic                      core_clk,
  input wire logic                      reset_n,
  input wire logic [31:0]               reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire cifam_pkg::cifam_cmd_type  cmd_req,
  input wire logic                      busy,
  input wire logic                      ram_rd,
  input wire logic                      ram_wr,
  input wire logic [5:0]                ram_addr,
  input wire cifam_pkg::cifam_mask_type ram_wdata,
  input wire cifam_pkg::cifam_mask_type ram_rdata,
  input wire cifam_pkg::cifam_filt_type filt_req,
  input wire logic                      filt_valid,
  input wire logic                      filt_match
);
  // ====================
  // decode of requests
  // ====================
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic go_rd;
  logic go_wr;
  logic lo;
  logic hi;
  // a request is only taken while idle
  assign go_rd = cmd_req.valid && cmd_req.mask_access && !busy
                 && !cmd_req.cmd_mask[7];
  assign go_wr = cmd_req.valid && cmd_req.mask_access && !busy
                 && cmd_req.cmd_mask[7];
  assign lo = reg_addr == cifam_pkg::IF1_ID_MASK_LOW_ADDR
              || reg_addr == cifam_pkg::IF2_ID_MASK_LOW_ADDR;
  assign hi = reg_addr == cifam_pkg::IF1_ID_MASK_HIGH_ADDR
              || reg_addr == cifam_pkg::IF2_ID_MASK_HIGH_ADDR;
  // ====================
  // assertions
  // ====================
  rd_xfer_a: assert property (go_rd |=> ram_rd && busy
    ##1 !ram_rd && busy ##1 !busy) else $error("read transfer timing");
  // writes may come back to back, so the pulse is judged per edge
  wr_xfer_a: assert property (go_wr |=> ram_wr)
    else $error("write transfer timing");
  wr_pulse_a: assert property (!go_wr |=> !ram_wr)
    else $error("ram write without request");
  xfer_addr_a: assert property ((go_rd || go_wr) |=>
    ram_addr == $past(cmd_req.obj_num)) else $error("object address");
  busy_wr_a: assert property (busy |-> !ram_wr)
    else $error("ram write while busy");
  lo_rsvd_a: assert property (reg_rd && lo |=>
    reg_rdata[31:16] == 16'h0000) else $error("low upper half");
  hi_rsvd_a: assert property (reg_rd && hi |=>
    reg_rdata[31:16] == 16'h0000 && reg_rdata[13])
    else $error("high reserved bits");
  unmap_rd_a: assert property (reg_rd && !lo && !hi |=>
    reg_rdata == 32'h0000_0000) else $error("unmapped read");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside slot");
  filt_lat_a: assert property (filt_req.valid |=> filt_valid)
    else $error("filter answer late");
  filt_open_a: assert property (filt_req.valid &&
    filt_req.obj_mask == '0 |=> filt_match) else $error("open mask");
  cover property (go_rd);
  cover property (go_wr);
  cover property (filt_valid && filt_match);
endmodule : cifam_regs_monitor
bind cifam_regs cifam_regs_monitor i_mon (.core_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_req, .busy, .ram_rd,
  .ram_wr, .ram_addr, .ram_wdata, .ram_rdata, .filt_req, .filt_valid,
  .filt_match);
`default_nettype wire

/* cifam_ram_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cifam_ram_model (
  input  wire logic                      core_clk,
  input  wire logic                      ram_rd,
  input  wire logic                      ram_wr,
  input  wire logic [5:0]                ram_addr,
  input  wire cifam_pkg::cifam_mask_type ram_wdata,
  output var  cifam_pkg::cifam_mask_type ram_rdata
);
  // ====================
  // object store
  // ====================
  cifam_pkg::cifam_mask_type mem [64];
  initial ram_rdata = '0;
  // word kept as sent; outside the answer slot the data toggles
  always @(posedge core_clk)
  begin
    if (ram_wr)
      mem[ram_addr] <= ram_wdata;
    ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
  end
endmodule : cifam_ram_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("unexpected %s: expected %h seen %h", n, e, a); \
    end \
  end
module testbench;
  localparam logic [31:0] L1 = cifam_pkg::IF1_ID_MASK_LOW_ADDR;
  localparam logic [31:0] H1 = cifam_pkg::IF1_ID_MASK_HIGH_ADDR;
  localparam logic [31:0] L2 = cifam_pkg::IF2_ID_MASK_LOW_ADDR;
  localparam logic [31:0] H2 = cifam_pkg::IF2_ID_MASK_HIGH_ADDR;
  logic                      core_clk, reset_n, reg_wr, reg_rd, busy;
  logic                      ram_rd, ram_wr, filt_valid, filt_match;
  logic [31:0]               reg_addr, reg_wdata, reg_rdata;
  logic [5:0]                ram_addr;
  cifam_pkg::cifam_cmd_type  cmd_req;
  cifam_pkg::cifam_mask_type ram_wdata, ram_rdata;
  cifam_pkg::cifam_filt_type filt_req;
  int                        failures, samples_checked, cycles;

  cifam_regs i_cifam_regs (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cmd_req, .busy, .ram_rd, .ram_wr,
    .ram_addr, .ram_wdata, .ram_rdata, .filt_req, .filt_valid,
    .filt_match);
  cifam_ram_model i_cifam_ram_model (.core_clk, .ram_rd, .ram_wr,
    .ram_addr, .ram_wdata, .ram_rdata);

  // ====================
  // clock and hang guard
  // ====================
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // run needs under a hundred cycles; the ceiling leaves wide margin
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      finish_test();
    end
  end

  // ====================
  // bus tasks
  // ====================
  task automatic wr(input logic [31:0] a, d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  // a read transfer is busy two cycles, so wait three before moving on
  task automatic xfer(input logic s, w, m, input logic [5:0] n);
    @(posedge core_clk);
    cmd_req <= {1'b1, s, w, 7'h00, m, n};
    @(posedge core_clk);
    cmd_req.valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : xfer
  task automatic f(input logic [28:0] a, input logic b, c,
                   input logic [28:0] oi, input logic od, ox,
                   input logic [30:0] m, input logic e);
    @(posedge core_clk);
    filt_req <= {1'b1, a, b, c, oi, od, ox, m};
    @(posedge core_clk);
    filt_req.valid <= 1'b0;
    #1;
    `CHK("filt_valid", 1'b1, filt_valid)
    `CHK("filt_match", e, filt_match)
  endtask : f

  // ====================
  // scenarios
  // ====================
  task automatic t_reset;
    rd(L1, 32'h0000_ffff);
    rd(H1, 32'h0000_efff);
    rd(L2, 32'h0000_ffff);
    rd(H2, 32'h0000_efff);
  endtask : t_reset
  task automatic t_regs;
    wr(H1, 32'hffff_ffff);
    rd(H1, 32'h0000_ffff);
    wr(H1, 32'h0000_0000);
    rd(H1, 32'h0000_2000);
    wr(L1, 32'hffff_ffff);
    rd(L1, 32'h0000_ffff);
    wr(L2, 32'h0000_1234);
    rd(L1, 32'h0000_ffff);
    rd(L2, 32'h0000_1234);
    wr(32'h4005_0030, 32'hffff_ffff);
    rd(32'h4005_0030, 32'h0000_0000);
  endtask : t_regs
  // store through one interface, fetch back through the other
  task automatic t_xfer;
    wr(L1, 32'h0000_a5c3);
    wr(H1, 32'h0000_4abc);
    xfer(1'b0, 1'b1, 1'b1, 6'h05);
    `CHK("ram_wdata", 31'h2abc_a5c3, ram_wdata)
    `CHK("ram_addr", 6'h05, ram_addr)
    wr(L1, 32'h0000_0000);
    xfer(1'b1, 1'b0, 1'b1, 6'h05);
    rd(L2, 32'h0000_a5c3);
    rd(H2, 32'h0000_6abc);
    rd(L1, 32'h0000_0000);
    // without mask access the buffer must keep what software wrote
    wr(L2, 32'h0000_0000);
    xfer(1'b1, 1'b0, 1'b0, 6'h05);
    rd(L2, 32'h0000_0000);
  endtask : t_xfer
  task automatic t_filt;
    f(29'h1fff_ffff, '0, '1, '0, '0, '1, '0, '1);
    f(29'h10_0000, '0, '1, '0, '0, '1, {2'h0, 29'h10_0000}, '0);
    f(29'h8, '0, '0, '0, '0, '0, {2'h0, 29'h8}, '1);
    f(29'h8, '0, '1, '0, '0, '1, {2'h0, 29'h8}, '0);
    f('0, '1, '1, '0, '0, '1, {2'h1, 29'h0}, '0);
    f('0, '1, '1, '0, '0, '1, {2'h2, 29'h0}, '1);
    f('0, '0, '0, '0, '0, '1, {2'h2, 29'h0}, '0);
    f('0, '0, '0, '0, '0, '1, {2'h1, 29'h0}, '1);
  endtask : t_filt

  task automatic finish_test;
    $display("failures %0d samples_checked %0d", failures,
             samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // ====================
  // main sequence
  // ====================
  initial
  begin
    reset_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmd_req = '0;
    filt_req = '0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_xfer();
    t_filt();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
